// ==== scss_asserts.sv ====
// Checker for the serial slave settings block.
// Sees only ports of scss_settings; bound into every instance of it.
`timescale 1ns/1ns
`default_nettype none
module scss_asserts
  import scss_pkg::*;
(
  input wire logic            clk_sys_i,
  input wire logic            sys_rst_i,
  input wire scss_cfg_t       cfg_o,
  input wire logic            cfg_write_i,
  input wire logic            cfg_reject_o,
  input wire scss_fault_t     fault_i,
  input wire logic            fault_clear_i,
  input wire logic [7:0]      serial_error_flags_o,
  input wire logic            comm_error_o,
  input wire scss_act_t       fault_stop_o,
  input wire logic            msg_done_i,
  input wire logic [5:0]      msg_addr_i,
  input wire logic            msg_execute_o,
  input wire logic            tx_valid_o,
  input wire logic            driver_enable_o,
  input wire logic [MF_N-1:0] mf_serial_i,
  input wire logic [MF_N-1:0] multi_function_input_pins_i,
  input wire logic [MF_N-1:0] mf_command_o,
  input wire logic [15:0]     bit_rate_o
);
  // Fault pulses placed on their status bit positions.
  logic [7:0] fault_map;
  assign fault_map = {1'b0, fault_i.tmo, fault_i.frm, fault_i.ovr,
                      fault_i.par, 1'b0, fault_i.len, fault_i.crc};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ======
  // Properties
  flag_set_a:
    assert property (fault_map != 8'h00 |=> (serial_error_flags_o
      & $past(fault_map)) == $past(fault_map)) else $error("flag not set");
  unused_bits_a:
    assert property ((serial_error_flags_o & 8'h84) == 8'h00)
      else $error("unused flag bit set");
  flags_sticky_a:
    assert property (!fault_clear_i |=> (serial_error_flags_o
      & $past(serial_error_flags_o)) == $past(serial_error_flags_o))
      else $error("flag dropped without clear");
  comm_err_a:
    assert property (comm_error_o == |(serial_error_flags_o
      & (cfg_o.timeout_detect_setting ? 8'h7f : 8'h3f)))
      else $error("comm error level wrong");
  stop_action_a:
    assert property (fault_stop_o == scss_act_t'(cfg_o.comm_fault_action))
      else $error("stop action wrong");
  exec_cause_a:
    assert property (msg_execute_o |-> $past(msg_done_i) && $past(msg_addr_i)
      == $past(cfg_o.node_address_setting) && $past(msg_addr_i) != 6'h00)
      else $error("execute without addressed message");
  no_reply_a:
    assert property (msg_done_i && (msg_addr_i == 6'h00 || msg_addr_i
      != cfg_o.node_address_setting) |=> !msg_execute_o)
      else $error("execute on broadcast or foreign address");
  drv_en_a:
    assert property (tx_valid_o || !cfg_o.driver_enable_control
      |-> driver_enable_o) else $error("driver enable low");
  reject_keep_a:
    assert property (cfg_reject_o |-> $stable(cfg_o) && $past(cfg_write_i))
      else $error("refused write changed settings");
  mf_or_a:
    assert property (mf_command_o == (mf_serial_i
      | $past(multi_function_input_pins_i, 2)))
      else $error("command OR wrong");
  rate_dec_a:
    assert property (bit_rate_o == 16'h000c << cfg_o.line_rate_setting)
      else $error("bit rate decode wrong");
endmodule : scss_asserts
bind scss_settings scss_asserts u_scss_asserts (.clk_sys_i, .sys_rst_i,
  .cfg_o, .cfg_write_i, .cfg_reject_o, .fault_i, .fault_clear_i,
  .serial_error_flags_o, .comm_error_o, .fault_stop_o, .msg_done_i,
  .msg_addr_i, .msg_execute_o, .tx_valid_o, .driver_enable_o, .mf_serial_i,
  .multi_function_input_pins_i, .mf_command_o, .bit_rate_o);
`default_nettype wire

// ==== scss_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; the drain side may stall at any time.
`timescale 1ns/1ns
`default_nettype none
module scss_buf2
  import scss_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire scss_word_t in_data_i,
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  output scss_word_t      out_data_o,
  output logic            out_valid_o,
  input  wire logic       out_ready_i
);

  // ==========================================================================
  // Storage
  // ==========================================================================
  scss_word_t mem_reg [2];
  scss_word_t mem_next [2];
  logic       rd_reg, rd_next, wr_reg, wr_next;
  logic [1:0] cnt_reg, cnt_next;
  logic       push, pop;

  // Handshakes; full and empty come straight from the count.
  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Next pointers, count and storage.
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg ^ push;
    rd_next  = rd_reg ^ pop;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    if (push) begin
      mem_next[wr_reg] = in_data_i;
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : scss_buf2
`default_nettype wire

// ==== scss_pkg.sv ====
// Package for the serial slave settings block: settings layout, codes,
// reset values and timing constants.
// Assumes a 25 MHz system clock and one slave on a shared two-wire line.
package scss_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam logic [6:0]  DELAY_MIN_MS  = 7'h05;
  localparam logic [6:0]  DELAY_MAX_MS  = 7'h41;

  // ==========================================================================
  // Settings ranges and values after reset
  // ==========================================================================
  localparam logic [5:0]  ADDR_MAX      = 6'h20;
  localparam logic [5:0]  ADDR_RESET    = 6'h1f;
  localparam logic [5:0]  ADDR_BCAST    = 6'h00;
  localparam logic [2:0]  RATE_RESET    = 3'h3;
  localparam logic [2:0]  RATE_MAX      = 3'h4;
  localparam logic [1:0]  PAR_RESET     = 2'h0;
  localparam logic [1:0]  PAR_MAX       = 2'h2;
  localparam logic [1:0]  ACT_RESET     = 2'h3;
  localparam logic        TMO_RESET     = 1'b1;
  localparam logic        DRV_RESET     = 1'b1;
  localparam logic [2:0]  FSRC_RESET    = 3'h1;
  localparam logic [2:0]  FSRC_MAX      = 3'h4;
  localparam logic [1:0]  RSRC_RESET    = 2'h1;
  localparam logic [15:0] UNIT_RESET    = 16'h0000;
  localparam logic [15:0] UNIT_PCT      = 16'h0001;
  localparam logic [15:0] UNIT_RPM_MAX  = 16'h0027;
  localparam logic [15:0] UNIT_MAX      = 16'h9c3f;

  // ==========================================================================
  // Error status bit positions
  // ==========================================================================
  localparam int unsigned ERR_CRC       = 0;
  localparam int unsigned ERR_LEN       = 1;
  localparam int unsigned ERR_PAR       = 3;
  localparam int unsigned ERR_OVR       = 4;
  localparam int unsigned ERR_FRM       = 5;
  localparam int unsigned ERR_TMO       = 6;
  localparam logic [7:0]  ERR_USED_MASK = 8'h7b;

  // Number of multi-function contact inputs.
  localparam int unsigned MF_N          = 5;

  // Selector encodings.
  typedef enum logic [2:0] {
    SCSS_FSRC_KEYPAD, SCSS_FSRC_ANALOG, SCSS_FSRC_SERIAL,
    SCSS_FSRC_OPTION, SCSS_FSRC_PULSE
  } scss_fsrc_t;

  typedef enum logic [1:0] {
    SCSS_RSRC_KEYPAD, SCSS_RSRC_TERMINAL, SCSS_RSRC_SERIAL, SCSS_RSRC_OPTION
  } scss_rsrc_t;

  typedef enum logic [1:0] {
    SCSS_ACT_RAMP, SCSS_ACT_COAST, SCSS_ACT_ESTOP, SCSS_ACT_RUN
  } scss_act_t;

  typedef enum logic [1:0] {
    SCSS_UNIT_HZ, SCSS_UNIT_PCT, SCSS_UNIT_RPM, SCSS_UNIT_USER
  } scss_unit_t;

  // One settings write as it arrives from the parameter path.
  typedef struct packed {
    logic [5:0]  node_address_setting;
    logic [2:0]  line_rate_setting;
    logic [1:0]  parity_setting;
    logic [1:0]  comm_fault_action;
    logic        timeout_detect_setting;
    logic [6:0]  reply_delay_setting;
    logic        driver_enable_control;
    logic [2:0]  frequency_source_select;
    logic [1:0]  run_source_select;
    logic [15:0] frequency_unit_select;
  } scss_cfg_t;

  // Fault reports from the character receiver, one-cycle pulses.
  typedef struct packed {
    logic crc;
    logic len;
    logic par;
    logic ovr;
    logic frm;
    logic tmo;
  } scss_fault_t;

  // One reply byte in flight.
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } scss_word_t;

endpackage : scss_pkg

// ==== scss_settings.sv ====
// Settings and status logic for the drive's serial slave port.
// Assumes a character receiver that reports faults and message ends, and a
// transmitter that drains reply bytes; the line pins sit outside.
// Functional notes
// [RULE_01] Frequency reference from keypad, analog, serial, option or pulse.
// [RULE_02] Run command from keypad, terminals, serial link or option card.
// [RULE_03] Node address holds 0 to 20 hex, reset value 1F hex.
// [RULE_04] Node address zero suppresses every response.
// [RULE_05] Line rate selector 0..4 gives 1200 to 19200 bit/s, default 3.
// [RULE_06] Parity selector: 0 none, 1 even, 2 odd; default none.
// [RULE_07] Comm error action: ramp, coast, emergency stop or keep running.
// [RULE_08] Timeout counts as comm error only when detection is enabled.
// [RULE_09] Reply waits 5 to 65 ms after a message is received.
// [RULE_10] Driver enable only while sending when set, else always on.
// [RULE_11] Error byte flags CRC, length, parity, overrun, framing, timeout.
// [RULE_12] Serial access works whatever the reference and run sources are.
// [RULE_13] Each multi-function command ORs serial bit with contact terminal.
// [RULE_14] Units setting picks Hz, percent, r/min or user display scaling.
// [RULE_15] Master starts each exchange; addressed slave executes then answers.
// [RULE_16] Address zero messages are broadcast and never answered.
// [RULE_17] Error bits stay set until their cause is cleared.
`timescale 1ns/1ns
`default_nettype none
module scss_settings
  import scss_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire scss_cfg_t        cfg_data_i,
  input  wire logic             cfg_write_i,
  output scss_cfg_t             cfg_o,
  output logic                  cfg_reject_o,
  input  wire scss_fault_t      fault_i,
  input  wire logic             fault_clear_i,
  output logic [7:0]            serial_error_flags_o,
  output logic                  comm_error_o,
  output scss_act_t             fault_stop_o,
  input  wire logic             msg_done_i,
  input  wire logic [5:0]       msg_addr_i,
  output logic                  msg_execute_o,
  input  wire scss_word_t       reply_data_i,
  input  wire logic             reply_valid_i,
  output logic                  reply_ready_o,
  output scss_word_t            tx_data_o,
  output logic                  tx_valid_o,
  input  wire logic             tx_ready_i,
  input  wire logic             tx_busy_i,
  output logic                  driver_enable_o,
  input  wire logic [MF_N-1:0]  mf_serial_i,
  input  wire logic [MF_N-1:0]  multi_function_input_pins_i,
  output logic [MF_N-1:0]       mf_command_o,
  output scss_fsrc_t            freq_source_o,
  output scss_rsrc_t            run_source_o,
  output logic                  serial_freq_active_o,
  output logic                  serial_run_active_o,
  output logic [15:0]           bit_rate_o,
  output logic                  parity_enable_o,
  output logic                  parity_odd_o,
  output scss_unit_t            unit_mode_o
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Bit rate in hundreds of bit/s for a selector value.
  function automatic logic [15:0] rate_of(input logic [2:0] sel);
    case (sel)
      3'h0:    rate_of = 16'h000c;
      3'h1:    rate_of = 16'h0018;
      3'h2:    rate_of = 16'h0030;
      3'h3:    rate_of = 16'h0060;
      3'h4:    rate_of = 16'h00c0;
      default: rate_of = 16'h0060;
    endcase
  endfunction : rate_of

  // A settings word is legal only when every field is in range.
  function automatic logic cfg_ok(input scss_cfg_t c);
    cfg_ok = (c.node_address_setting <= ADDR_MAX)
          && (c.line_rate_setting <= RATE_MAX)
          && (c.parity_setting <= PAR_MAX)
          && (c.reply_delay_setting >= DELAY_MIN_MS)
          && (c.reply_delay_setting <= DELAY_MAX_MS)
          && (c.frequency_source_select <= FSRC_MAX)
          && (c.frequency_unit_select <= UNIT_MAX);
  endfunction : cfg_ok

  // ==========================================================================
  // Settings store
  // ==========================================================================
  scss_cfg_t cfg_reg, cfg_next;
  logic      rej_reg, rej_next;
  logic [MF_N-1:0] pin1_reg, pin1_next, pin2_reg, pin2_next;

  // Out-of-range writes are refused whole and flagged for one cycle.
  always_comb begin
    cfg_next = cfg_reg;
    rej_next = 1'b0;
    pin1_next = multi_function_input_pins_i; // Pins pass two flip-flops.
    pin2_next = pin1_reg;
    if (cfg_write_i) begin
      if (cfg_ok(cfg_data_i)) begin
        cfg_next = cfg_data_i; // [RULE_03]
      end else begin
        rej_next = 1'b1;
      end
    end
  end

  // Reset gives the factory settings.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_reg.node_address_setting    <= ADDR_RESET; // [RULE_03]
      cfg_reg.line_rate_setting       <= RATE_RESET; // [RULE_05]
      cfg_reg.parity_setting          <= PAR_RESET; // [RULE_06]
      cfg_reg.comm_fault_action       <= ACT_RESET;
      cfg_reg.timeout_detect_setting  <= TMO_RESET; // [RULE_08]
      cfg_reg.reply_delay_setting     <= DELAY_MIN_MS; // [RULE_09]
      cfg_reg.driver_enable_control   <= DRV_RESET;
      cfg_reg.frequency_source_select <= FSRC_RESET;
      cfg_reg.run_source_select       <= RSRC_RESET;
      cfg_reg.frequency_unit_select   <= UNIT_RESET;
      rej_reg                         <= 1'b0;
      pin1_reg                        <= '0;
      pin2_reg                        <= '0;
    end else begin
      cfg_reg <= cfg_next;
      rej_reg <= rej_next;
      pin1_reg <= pin1_next;
      pin2_reg <= pin2_next;
    end
  end

  assign cfg_o        = cfg_reg;
  assign cfg_reject_o = rej_reg;

  // Source, line and unit decoding for the rest of the drive.
  always_comb begin
    freq_source_o        = scss_fsrc_t'(cfg_reg.frequency_source_select); // [RULE_01]
    run_source_o         = scss_rsrc_t'(cfg_reg.run_source_select); // [RULE_02]
    serial_freq_active_o = (freq_source_o == SCSS_FSRC_SERIAL);
    serial_run_active_o  = (run_source_o == SCSS_RSRC_SERIAL);
    bit_rate_o           = rate_of(cfg_reg.line_rate_setting); // [RULE_05]
    parity_enable_o      = (cfg_reg.parity_setting != 2'h0); // [RULE_06]
    parity_odd_o         = (cfg_reg.parity_setting == 2'h2); // [RULE_06]
    if (cfg_reg.frequency_unit_select == UNIT_RESET) begin
      unit_mode_o = SCSS_UNIT_HZ; // [RULE_14]
    end else if (cfg_reg.frequency_unit_select == UNIT_PCT) begin
      unit_mode_o = SCSS_UNIT_PCT; // [RULE_14]
    end else if (cfg_reg.frequency_unit_select <= UNIT_RPM_MAX) begin
      unit_mode_o = SCSS_UNIT_RPM; // [RULE_14]
    end else begin
      unit_mode_o = SCSS_UNIT_USER; // [RULE_14]
    end
  end

  // Multi-function commands: serial bits act whatever the sources are.
  genvar g;
  generate
    for (g = 0; g < MF_N; g++) begin : g_mf // [RULE_12]
      assign mf_command_o[g] = mf_serial_i[g] | pin2_reg[g]; // [RULE_13]
    end
  endgenerate

  // ==========================================================================
  // Error status
  // ==========================================================================
  logic [7:0] err_reg, err_next;
  logic [7:0] err_set;

  // Sticky flags; a new fault wins over a clear in the same cycle.
  always_comb begin
    err_set          = 8'h00;
    err_set[ERR_CRC] = fault_i.crc; // [RULE_11]
    err_set[ERR_LEN] = fault_i.len;
    err_set[ERR_PAR] = fault_i.par;
    err_set[ERR_OVR] = fault_i.ovr;
    err_set[ERR_FRM] = fault_i.frm;
    err_set[ERR_TMO] = fault_i.tmo;
    err_next = fault_clear_i ? 8'h00 : err_reg; // [RULE_17]
    err_next = (err_next | err_set) & ERR_USED_MASK; // [RULE_11]
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_reg <= 8'h00;
    end else begin
      err_reg <= err_next;
    end
  end

  assign serial_error_flags_o = err_reg;
  // Timeout only counts when detection is on.
  assign comm_error_o = |(err_reg & ~(8'h01 << ERR_TMO))
                      | (err_reg[ERR_TMO] & cfg_reg.timeout_detect_setting); // [RULE_08]
  assign fault_stop_o = scss_act_t'(cfg_reg.comm_fault_action); // [RULE_07]

  // ==========================================================================
  // Reply sequencing
  // ==========================================================================
  typedef enum {ST_IDLE, ST_WAIT, ST_SEND} scss_state_t;
  scss_state_t st_reg, st_next;
  logic [14:0] cyc_reg, cyc_next;
  logic [6:0]  ms_reg, ms_next;
  logic        exe_reg, exe_next;
  logic        hold_reg, hold_next;
  logic        buf_in_ready;
  logic        gate;
  logic        buf_out_valid;

  // Only a message to our own nonzero address is executed and answered.
  always_comb begin
    st_next   = st_reg;
    cyc_next  = cyc_reg;
    ms_next   = ms_reg;
    exe_next  = 1'b0;
    hold_next = hold_reg;
    case (st_reg)
      ST_IDLE: begin
        if (msg_done_i && (msg_addr_i != ADDR_BCAST) // [RULE_16]
            && (cfg_reg.node_address_setting != ADDR_BCAST) // [RULE_04]
            && (msg_addr_i == cfg_reg.node_address_setting)) begin
          exe_next = 1'b1; // [RULE_15]
          st_next  = ST_WAIT;
          cyc_next = 15'h0000;
          ms_next  = 7'h00;
        end
      end
      ST_WAIT: begin
        if (cyc_reg == 15'(CYC_PER_MS - 1)) begin
          cyc_next = 15'h0000;
          ms_next  = ms_reg + 7'h01;
          if (ms_reg + 7'h01 >= cfg_reg.reply_delay_setting) begin
            st_next = ST_SEND; // [RULE_09]
          end
        end else begin
          cyc_next = cyc_reg + 15'h0001;
        end
      end
      ST_SEND: begin
        if (tx_valid_o && tx_ready_i && tx_data_o.last) begin
          hold_next = 1'b1;
        end
        if (hold_reg && !tx_busy_i && !tx_valid_o) begin
          hold_next = 1'b0;
          st_next   = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg   <= ST_IDLE;
      cyc_reg  <= 15'h0000;
      ms_reg   <= 7'h00;
      exe_reg  <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cyc_reg  <= cyc_next;
      ms_reg   <= ms_next;
      exe_reg  <= exe_next;
      hold_reg <= hold_next;
    end
  end

  assign msg_execute_o = exe_reg;

  // Reply bytes pass the buffer only once the wait has run out.
  assign gate          = (st_reg == ST_SEND) && !hold_reg;
  assign reply_ready_o = buf_in_ready;

  scss_buf2 u_buf (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (reply_data_i),
    .in_valid_i  (reply_valid_i),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (tx_data_o),
    .out_valid_o (buf_out_valid),
    .out_ready_i (tx_ready_i && gate)
  );

  assign tx_valid_o = buf_out_valid && gate;

  // Driver enable follows sending, or stays on when control is off.
  assign driver_enable_o = !cfg_reg.driver_enable_control
                         || (st_reg == ST_SEND); // [RULE_10]

endmodule : scss_settings
`default_nettype wire

// ==== scss_testbench.sv ====
// Self-checking testbench for the serial slave settings block.
// Assumes scss_pkg, the design, its checker and the transmitter model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import scss_pkg::*;
  localparam time DLY = 2;
  // ======
  // Clock, design inputs and outputs
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, cfg_write_i = 1'b0;
  logic fault_clear_i = 1'b0, msg_done_i = 1'b0, reply_valid_i = 1'b0;
  logic [5:0] msg_addr_i = 6'h00;
  logic [MF_N-1:0] mf_serial_i = '0, multi_function_input_pins_i = '0;
  scss_cfg_t cfg_data_i = '0, cfg_o, base, prev, c;
  scss_fault_t fault_i = '0;
  scss_word_t reply_data_i = '{8'h5a, 1'b0}, tx_data_o;
  scss_act_t fault_stop_o;
  scss_fsrc_t freq_source_o;
  scss_rsrc_t run_source_o;
  scss_unit_t unit_mode_o;
  logic [7:0] serial_error_flags_o, exp_flags;
  logic [MF_N-1:0] mf_command_o;
  logic [15:0] bit_rate_o;
  logic cfg_reject_o, comm_error_o, msg_execute_o, reply_ready_o;
  logic tx_valid_o, tx_ready_i, tx_busy_i, driver_enable_o;
  logic serial_freq_active_o, serial_run_active_o;
  logic parity_enable_o, parity_odd_o;
  logic [15:0] units [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0027,
                             16'h0028, 16'h9c3f};
  logic [1:0] umode [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [7:0] bitpos [6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};
  int n_errors = 0;
  int checks_done = 0;
  int n;
  always #20 clk_sys_i = ~clk_sys_i;
  // The block under test and the transmitter on its far side.
  scss_settings DUT (.clk_sys_i, .sys_rst_i, .cfg_data_i, .cfg_write_i,
    .cfg_o, .cfg_reject_o, .fault_i, .fault_clear_i, .serial_error_flags_o,
    .comm_error_o, .fault_stop_o, .msg_done_i, .msg_addr_i, .msg_execute_o,
    .reply_data_i, .reply_valid_i, .reply_ready_o, .tx_data_o, .tx_valid_o,
    .tx_ready_i, .tx_busy_i, .driver_enable_o, .mf_serial_i,
    .multi_function_input_pins_i, .mf_command_o, .freq_source_o,
    .run_source_o, .serial_freq_active_o, .serial_run_active_o, .bit_rate_o,
    .parity_enable_o, .parity_odd_o, .unit_mode_o);
  scss_tx_model partner (.clk_sys_i, .sys_rst_i, .tx_data_i(tx_data_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .tx_busy_o(tx_busy_i));
  // ======
  // Tasks
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input scss_cfg_t w);
    @(posedge clk_sys_i) #DLY;
    cfg_data_i = w;
    cfg_write_i = 1'b1;
    @(posedge clk_sys_i) #DLY;
    cfg_write_i = 1'b0;
  endtask : wr
  task automatic fl(input scss_fault_t f, input logic clr);
    @(posedge clk_sys_i) #DLY;
    fault_i = f;
    fault_clear_i = clr;
    @(posedge clk_sys_i) #DLY;
    fault_i = '0;
    fault_clear_i = 1'b0;
  endtask : fl
  task automatic msg(input logic [5:0] a, input logic exp);
    @(posedge clk_sys_i) #DLY;
    msg_done_i = 1'b1;
    msg_addr_i = a;
    @(posedge clk_sys_i) #DLY;
    msg_done_i = 1'b0;
    check("execute", msg_execute_o, exp);
  endtask : msg
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Watchdog: the tests need about 110 cycles.
  initial begin
    #(40 * 20000);
    n_errors++;
    finish_test();
  end
  // Main sequence of tests.
  initial begin
    repeat (16) @(posedge clk_sys_i);
    #DLY sys_rst_i = 1'b0;
    base = '{6'h1f, 3'h3, 2'h0, 2'h3, 1'b1, 7'h05, 1'b1, 3'h1, 2'h1, 16'h0};
    check("cfg", cfg_o, base);
    check("flags", serial_error_flags_o, 8'h00);
    check("drv", driver_enable_o, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      c = base;
      c.line_rate_setting = i[2:0];
      c.frequency_source_select = i[2:0];
      c.run_source_select = i[1:0];
      c.comm_fault_action = i[1:0];
      c.parity_setting = 2'(i % 3);
      wr(c);
      check("reject", cfg_reject_o, 1'b0);
      check("rate", bit_rate_o, 16'h000c << i);
      check("fsrc", freq_source_o, i);
      check("fser", serial_freq_active_o, i == 2);
      check("rsrc", run_source_o, i % 4);
      check("rser", serial_run_active_o, i % 4 == 2);
      check("stop", fault_stop_o, i % 4);
      check("par", {parity_enable_o, parity_odd_o},
            {i % 3 != 0, i % 3 == 2});
    end
    foreach (units[k]) begin
      c = base;
      c.frequency_unit_select = units[k];
      wr(c);
      check("unit", unit_mode_o, umode[k]);
    end
    $display("test selectors done");
    prev = base;
    prev.node_address_setting = 6'h20;
    prev.reply_delay_setting = 7'h41;
    wr(prev);
    check("cfg", cfg_o, prev);
    for (int i = 0; i < 7; i++) begin
      c = prev;
      case (i)
        0: c.node_address_setting = 6'h21;
        1: c.line_rate_setting = 3'h5;
        2: c.parity_setting = 2'h3;
        3: c.reply_delay_setting = 7'h04;
        4: c.reply_delay_setting = 7'h42;
        5: c.frequency_source_select = 3'h5;
        default: c.frequency_unit_select = 16'h9c40;
      endcase
      wr(c);
      check("reject", cfg_reject_o, 1'b1);
      check("cfg", cfg_o, prev);
    end
    $display("test ranges done");
    exp_flags = 8'h00;
    for (int i = 0; i < 6; i++) begin
      fl(scss_fault_t'(6'h20 >> i), 1'b0);
      exp_flags |= bitpos[i];
      check("flags", serial_error_flags_o, exp_flags);
    end
    check("comm", comm_error_o, 1'b1);
    fl('0, 1'b1);
    check("flags", serial_error_flags_o, 8'h00);
    fl(6'h20, 1'b1);
    check("flags", serial_error_flags_o, 8'h01);
    fl('0, 1'b1);
    fl(6'h01, 1'b0);
    check("comm", comm_error_o, 1'b1);
    c = prev;
    c.timeout_detect_setting = 1'b0;
    c.driver_enable_control = 1'b0;
    wr(c);
    check("comm", comm_error_o, 1'b0);
    check("drv", driver_enable_o, 1'b1);
    $display("test faults done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) #DLY;
      mf_serial_i = 5'(i * 5);
      multi_function_input_pins_i = 5'h10 >> i;
      repeat (2) @(posedge clk_sys_i) #DLY;
      check("mf", mf_command_o, 5'(i * 5) | (5'h10 >> i));
    end
    c = prev;
    c.node_address_setting = 6'h00;
    wr(c);
    msg(6'h00, 1'b0);
    msg(6'h05, 1'b0);
    c.node_address_setting = 6'h05;
    wr(c);
    msg(6'h00, 1'b0);
    msg(6'h06, 1'b0);
    msg(6'h05, 1'b1);
    reply_valid_i = 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge clk_sys_i);
      if (reply_ready_o === 1'b1) n++;
    end
    @(posedge clk_sys_i) #DLY;
    reply_valid_i = 1'b0;
    check("queued", n, 2);
    check("txv", tx_valid_o, 1'b0);
    check("drv", driver_enable_o, 1'b0);
    msg(6'h05, 1'b0);
    $display("test messages done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire

// ==== scss_tx_model.sv ====
// Transmitter model: drains reply bytes, shifting each for ten cycles.
// Assumes the block's byte stream handshake on the one system clock.
`timescale 1ns/1ns
`default_nettype none
module scss_tx_model
  import scss_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire scss_word_t tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic            tx_busy_o
);
  logic [3:0] shift_reg;
  // Takes a new byte only once the previous one has left the line.
  assign tx_ready_o = !sys_rst_i && shift_reg == 4'h0;
  assign tx_busy_o  = shift_reg != 4'h0;
  // Counts down the character time of the byte being shifted.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_reg <= 4'h0;
    end else if (tx_valid_i && tx_ready_o) begin
      shift_reg <= 4'ha;
    end else if (shift_reg != 4'h0) begin
      shift_reg <= shift_reg - 4'h1;
    end
  end
endmodule : scss_tx_model
`default_nettype wire
